// [hdl/lbp_ctrl.sv]
/*
  Enable, dimming and fault sequencing for a dual-sink LED boost driver.
  Chooses duty dimming when the single-wire interface is not taken up,
  runs the pin low-time timeouts, gates the power switch on faults and
  offers a small register port with a level interrupt.
  Assumes pins and comparator flags are synchronous to the clock, and an
  outside decoder reports single-wire take-up and its brightness code.
*/
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module lbp_ctrl #(
  parameter int unsigned DIM_LOW_TMO = lbp_pkg::DIM_LOW_TMO_CYC,
  parameter int unsigned EN_LOW_TMO = lbp_pkg::EN_LOW_TMO_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Host pins
  input wire logic en_pin,
  input wire logic dim_pin,
  // Single-wire decoder status
  input wire logic onewire_ok,
  input wire logic [lbp_pkg::CODE_W-1:0] onewire_code,
  // Analog comparator flags
  input wire logic uvlo_flag,
  input wire logic drain_overvoltage_limit_hit,
  input wire logic sink_overvoltage_limit_hit,
  input wire logic ocp_flag,
  input wire logic otp_flag,
  // Power stage
  output logic power_switch_on,
  output logic sink_enable,
  output logic [lbp_pkg::LVL_W-1:0] led_current_sink_input_level,
  output logic duty_mode,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Interrupt
  output logic irq
);

  localparam logic [lbp_pkg::TMO_W-1:0] TMO_ONE = 20'h00001;
  localparam logic [lbp_pkg::TMO_W-1:0] TMO_MAX = '1;
  localparam logic [lbp_pkg::TMO_W-1:0] DIM_TMO_V = lbp_pkg::TMO_W'(DIM_LOW_TMO);
  localparam logic [lbp_pkg::TMO_W-1:0] EN_TMO_V = lbp_pkg::TMO_W'(EN_LOW_TMO);
  localparam logic [lbp_pkg::DET_W-1:0] DET_LAST = lbp_pkg::DET_W'(lbp_pkg::DETECT_CYC - 1);
  localparam logic [lbp_pkg::DET_W-1:0] DET_ONE = 13'h0001;
  localparam logic [lbp_pkg::SWC_W-1:0] SWC_LAST = lbp_pkg::SWC_W'(lbp_pkg::SW_PERIOD_CYC - 1);
  localparam logic [lbp_pkg::SWC_W-1:0] SWC_ONE = 6'h01;

  function automatic logic [lbp_pkg::TMO_W-1:0] low_count(
    input logic pin, input logic [lbp_pkg::TMO_W-1:0] cnt);
    if (pin) begin
      low_count = '0;
    end else if (cnt == TMO_MAX) begin
      low_count = cnt;
    end else begin
      low_count = cnt + TMO_ONE;
    end
  endfunction : low_count

  // ==========================================================
  // Switching cycle divider
  logic [lbp_pkg::SWC_W-1:0] swc_ff, nxt_swc;
  logic cyc_start;

  always_comb begin
    cyc_start = (swc_ff == SWC_LAST);
    nxt_swc = cyc_start ? '0 : swc_ff + SWC_ONE;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      swc_ff <= '0;
    end else begin
      swc_ff <= nxt_swc;
    end
  end

  // ==========================================================
  // Pin low-time timeouts
  logic [lbp_pkg::TMO_W-1:0] en_low_ff, nxt_en_low, dim_low_ff, nxt_dim_low;
  logic en_q_ff, dim_q_ff;
  logic en_tmo, dim_tmo, pin_toggle;

  always_comb begin
    nxt_en_low = low_count(en_pin, en_low_ff);
    nxt_dim_low = low_count(dim_pin, dim_low_ff);
    en_tmo = (en_low_ff >= EN_TMO_V);
    dim_tmo = (dim_low_ff >= DIM_TMO_V);
    pin_toggle = (en_q_ff & ~en_pin) | (dim_q_ff & ~dim_pin);
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      en_low_ff <= '0;
      dim_low_ff <= '0;
      en_q_ff <= 1'b0;
      dim_q_ff <= 1'b0;
    end else begin
      en_low_ff <= nxt_en_low;
      dim_low_ff <= nxt_dim_low;
      en_q_ff <= en_pin;
      dim_q_ff <= dim_pin;
    end
  end

  // ==========================================================
  // Registers
  logic ctrl_ff, nxt_ctrl;
  logic [lbp_pkg::EV_W-1:0] ist_ff, nxt_ist, imask_ff, nxt_imask, events;
  logic [31:0] rdata_ff, nxt_rdata;
  logic irq_ff, nxt_irq;
  lbp_pkg::lbp_state_t st_ff;
  logic mode_ff;
  logic [lbp_pkg::LVL_W-1:0] level_ff;

  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_imask = imask_ff;
    nxt_ist = ist_ff;
    nxt_rdata = 32'h0000_0000;
    if (reg_wr) begin
      unique case (reg_addr)
        lbp_pkg::OFS_CTRL: nxt_ctrl = reg_wdata[lbp_pkg::CTRL_ALLOW_BIT];
        lbp_pkg::OFS_IRQ_STAT: nxt_ist = ist_ff & ~reg_wdata[lbp_pkg::EV_W-1:0];
        lbp_pkg::OFS_IRQ_MASK: nxt_imask = reg_wdata[lbp_pkg::EV_W-1:0];
        default: ;
      endcase
    end
    // Set wins over a same-cycle clear
    nxt_ist = nxt_ist | events;
    if (reg_rd) begin
      unique case (reg_addr)
        lbp_pkg::OFS_CTRL: nxt_rdata = {31'h0, ctrl_ff};
        lbp_pkg::OFS_STAT: nxt_rdata = {27'h0, power_switch_on, sink_enable, mode_ff, st_ff};
        lbp_pkg::OFS_IRQ_STAT: nxt_rdata = {25'h0, ist_ff};
        lbp_pkg::OFS_IRQ_MASK: nxt_rdata = {25'h0, imask_ff};
        lbp_pkg::OFS_LEVEL: nxt_rdata = {22'h0, level_ff};
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
    nxt_irq = |(nxt_ist & nxt_imask);
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      ctrl_ff <= lbp_pkg::CTRL_RST;
      ist_ff <= lbp_pkg::EV_RST;
      imask_ff <= lbp_pkg::EV_RST;
      rdata_ff <= 32'h0000_0000;
      irq_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      ist_ff <= nxt_ist;
      imask_ff <= nxt_imask;
      rdata_ff <= nxt_rdata;
      irq_ff <= nxt_irq;
    end
  end

  // ==========================================================
  // Enable and fault state machine
  lbp_pkg::lbp_state_t nxt_st;
  logic [lbp_pkg::DET_W-1:0] det_ff, nxt_det;
  logic nxt_mode;
  logic ovp_any, shut_tmo;

  always_comb begin
    nxt_st = st_ff;
    nxt_det = det_ff;
    nxt_mode = mode_ff;
    ovp_any = drain_overvoltage_limit_hit | sink_overvoltage_limit_hit;
    // either timeout disables in both modes
    shut_tmo = en_tmo | dim_tmo;
    unique case (st_ff)
      lbp_pkg::ST_IDLE: begin
        if (en_pin && dim_pin && ctrl_ff) begin
          nxt_st = lbp_pkg::ST_DETECT;
          nxt_det = '0;
        end
      end
      lbp_pkg::ST_DETECT: begin
        nxt_det = det_ff + DET_ONE;
        if (shut_tmo || !ctrl_ff) begin
          nxt_st = lbp_pkg::ST_IDLE;
        end else if (onewire_ok) begin
          nxt_mode = 1'b0;
          nxt_st = lbp_pkg::ST_RUN;
        end else if (det_ff == DET_LAST) begin
          nxt_mode = 1'b1;
          nxt_st = lbp_pkg::ST_RUN;
        end
      end
      lbp_pkg::ST_RUN: begin
        if (ovp_any) begin
          nxt_st = lbp_pkg::ST_LATCH;
        end else if (shut_tmo || !ctrl_ff) begin
          nxt_st = lbp_pkg::ST_IDLE;
        end
      end
      lbp_pkg::ST_LATCH: begin
        // only a pin toggle or reset clears
        if (pin_toggle) begin
          nxt_st = lbp_pkg::ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      st_ff <= lbp_pkg::ST_IDLE;
      det_ff <= '0;
      mode_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      det_ff <= nxt_det;
      mode_ff <= nxt_mode;
    end
  end

  // ==========================================================
  // Power switch and sink command
  logic ocp_hold_ff, nxt_ocp_hold;
  logic sw_ff, nxt_sw, sink_en_ff, nxt_sink_en, run_ok;
  logic [lbp_pkg::LVL_W-1:0] nxt_level, duty_code;
  logic uvlo_q_ff, otp_q_ff;

  lbp_duty_meter u_duty (
    .clock(clock),
    .srst(srst),
    .dim_level(dim_pin),
    .duty_code(duty_code)
  );

  always_comb begin
    nxt_ocp_hold = ocp_flag | (ocp_hold_ff & ~cyc_start);
    run_ok = (st_ff == lbp_pkg::ST_RUN) & (nxt_st == lbp_pkg::ST_RUN)
           & ~uvlo_flag & ~otp_flag;
    nxt_sw = run_ok & ~nxt_ocp_hold & ~ovp_any;
    nxt_sink_en = run_ok;
    // duty-scaled level in duty mode
    // Single-wire code widened to the sink command width
    nxt_level = mode_ff ? duty_code : {onewire_code, onewire_code[lbp_pkg::CODE_W-1]};
    events = '0;
    events[lbp_pkg::EV_DRAIN_OVP] = drain_overvoltage_limit_hit & (st_ff == lbp_pkg::ST_RUN);
    events[lbp_pkg::EV_SINK_OVP] = sink_overvoltage_limit_hit & (st_ff == lbp_pkg::ST_RUN);
    events[lbp_pkg::EV_OCP] = ocp_flag & ~ocp_hold_ff;
    events[lbp_pkg::EV_UVLO] = uvlo_flag & ~uvlo_q_ff;
    events[lbp_pkg::EV_OTP] = otp_flag & ~otp_q_ff;
    events[lbp_pkg::EV_TMO] = shut_tmo & (st_ff == lbp_pkg::ST_RUN);
    events[lbp_pkg::EV_MODE] = (st_ff == lbp_pkg::ST_DETECT) & (nxt_st == lbp_pkg::ST_RUN);
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      ocp_hold_ff <= 1'b0;
      sw_ff <= 1'b0;
      sink_en_ff <= 1'b0;
      level_ff <= lbp_pkg::LVL_ZERO;
      uvlo_q_ff <= 1'b0;
      otp_q_ff <= 1'b0;
    end else begin
      ocp_hold_ff <= nxt_ocp_hold;
      sw_ff <= nxt_sw;
      sink_en_ff <= nxt_sink_en;
      level_ff <= nxt_level;
      uvlo_q_ff <= uvlo_flag;
      otp_q_ff <= otp_flag;
    end
  end

  // ==========================================================
  // Outputs
  assign power_switch_on = sw_ff;
  assign sink_enable = sink_en_ff;
  assign led_current_sink_input_level = level_ff;
  assign duty_mode = mode_ff;
  assign reg_rdata = rdata_ff;
  assign irq = irq_ff;

endmodule : lbp_ctrl
`default_nettype wire

// [hdl/lbp_duty_meter.sv]
/*
  Duty-cycle meter for the dimming pin: counts high time and period in
  clock cycles and divides them serially once per period.
  Assumes the dimming pin is synchronous to the clock.
*/
`timescale 1ns/1ps
`default_nettype none
module lbp_duty_meter (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Dimming pin
  input wire logic dim_level,
  // Measured duty, 0 to full scale
  output logic [lbp_pkg::LVL_W-1:0] duty_code
);

  localparam logic [lbp_pkg::TMO_W-1:0] CNT_MAX = '1;
  localparam logic [lbp_pkg::TMO_W-1:0] CNT_ONE = 20'h00001;

  logic dim_q_ff, nxt_dim_q;
  logic [lbp_pkg::TMO_W-1:0] hi_ff, nxt_hi, per_ff, nxt_per, dvs_ff, nxt_dvs;
  logic [lbp_pkg::TMO_W:0] rem_ff, nxt_rem;
  logic [lbp_pkg::LVL_W-1:0] quo_ff, nxt_quo, duty_ff, nxt_duty;
  logic [3:0] step_ff, nxt_step;
  logic busy_ff, nxt_busy;
  logic [lbp_pkg::TMO_W:0] shifted;
  logic rise;

  function automatic logic [lbp_pkg::TMO_W-1:0] sat_inc(input logic [lbp_pkg::TMO_W-1:0] v);
    sat_inc = (v == CNT_MAX) ? v : v + CNT_ONE;
  endfunction : sat_inc

  // ==========================================================
  // Counting and division
  always_comb begin
    rise = dim_level & ~dim_q_ff;
    nxt_dim_q = dim_level;
    nxt_hi = hi_ff;
    nxt_per = sat_inc(per_ff);
    nxt_dvs = dvs_ff;
    nxt_rem = rem_ff;
    nxt_quo = quo_ff;
    nxt_step = step_ff;
    nxt_busy = busy_ff;
    nxt_duty = duty_ff;
    shifted = {rem_ff[lbp_pkg::TMO_W-1:0], 1'b0};
    if (dim_level) begin
      nxt_hi = sat_inc(hi_ff);
    end
    if (rise) begin
      nxt_dvs = per_ff;
      nxt_rem = {1'b0, hi_ff};
      nxt_quo = lbp_pkg::LVL_ZERO;
      nxt_step = 4'h0;
      nxt_busy = 1'b1;
      nxt_hi = CNT_ONE;
      nxt_per = CNT_ONE;
    end else if (busy_ff) begin
      if (shifted >= {1'b0, dvs_ff}) begin
        nxt_rem = shifted - {1'b0, dvs_ff};
        nxt_quo = {quo_ff[lbp_pkg::LVL_W-2:0], 1'b1};
      end else begin
        nxt_rem = shifted;
        nxt_quo = {quo_ff[lbp_pkg::LVL_W-2:0], 1'b0};
      end
      nxt_step = step_ff + 4'h1;
      if (step_ff == 4'(lbp_pkg::DIV_STEPS - 1)) begin
        nxt_busy = 1'b0;
        nxt_duty = nxt_quo;
      end
    end
    // high past a whole period is steady high
    // Gives full scale long before the period counter saturates
    if (dim_level && !rise && !busy_ff && (hi_ff > dvs_ff)) begin
      nxt_duty = lbp_pkg::LVL_FULL;
    end
    if (per_ff == CNT_MAX) begin
      nxt_duty = dim_level ? lbp_pkg::LVL_FULL : lbp_pkg::LVL_ZERO;
      nxt_busy = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      dim_q_ff <= 1'b0;
      hi_ff <= '0;
      per_ff <= '0;
      dvs_ff <= '0;
      rem_ff <= '0;
      quo_ff <= '0;
      step_ff <= 4'h0;
      busy_ff <= 1'b0;
      duty_ff <= lbp_pkg::LVL_ZERO;
    end else begin
      dim_q_ff <= nxt_dim_q;
      hi_ff <= nxt_hi;
      per_ff <= nxt_per;
      dvs_ff <= nxt_dvs;
      rem_ff <= nxt_rem;
      quo_ff <= nxt_quo;
      step_ff <= nxt_step;
      busy_ff <= nxt_busy;
      duty_ff <= nxt_duty;
    end
  end

  assign duty_code = duty_ff;

endmodule : lbp_duty_meter
`default_nettype wire

// [hdl/lbp_pkg.sv]
/*
  Shared constants for the LED boost enable, dimming and fault controller:
  clock rate, timeouts, switching period, register map, field positions.
  Assumes a single 40 MHz clock and a synchronous active-high reset.
*/
package lbp_pkg;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_KHZ = 40000;
  localparam int unsigned DIM_LOW_TMO_US = 20000;
  localparam int unsigned EN_LOW_TMO_US = 2500;
  localparam int unsigned DETECT_US = 100;
  localparam int unsigned SW_FREQ_KHZ = 1200;
  localparam int unsigned DIM_LOW_TMO_CYC = DIM_LOW_TMO_US * CLK_KHZ / 1000;
  localparam int unsigned EN_LOW_TMO_CYC = EN_LOW_TMO_US * CLK_KHZ / 1000;
  localparam int unsigned DETECT_CYC = DETECT_US * CLK_KHZ / 1000;
  // Period no longer than the target, so round down
  localparam int unsigned SW_PERIOD_CYC = CLK_KHZ / SW_FREQ_KHZ;

  // ==========================================================
  // Widths
  localparam int TMO_W = 20;
  localparam int SWC_W = 6;
  localparam int DET_W = 13;
  localparam int LVL_W = 10;
  localparam int CODE_W = 9;
  localparam int DIV_STEPS = 10;
  localparam logic [LVL_W-1:0] LVL_FULL = 10'h3ff;
  localparam logic [LVL_W-1:0] LVL_ZERO = 10'h000;

  // ==========================================================
  // Register map
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
  localparam logic [7:0] OFS_LEVEL = 8'h10;
  localparam logic CTRL_RST = 1'b1;
  localparam int CTRL_ALLOW_BIT = 0;
  localparam int EV_W = 7;
  localparam int EV_DRAIN_OVP = 0;
  localparam int EV_SINK_OVP = 1;
  localparam int EV_OCP = 2;
  localparam int EV_UVLO = 3;
  localparam int EV_OTP = 4;
  localparam int EV_TMO = 5;
  localparam int EV_MODE = 6;
  localparam logic [EV_W-1:0] EV_RST = 7'h00;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    ST_IDLE, ST_DETECT, ST_RUN, ST_LATCH
  } lbp_state_t;

endpackage : lbp_pkg

// [tb/lbp_ctrl_properties.sv]
/*
  Port checker for lbp_ctrl: fault gating, latch-off, pin timeouts.
  Assumes it is bound to lbp_ctrl and shares its timeout parameters.
*/
`timescale 1ns/1ps
`default_nettype none
module lbp_ctrl_chk #(
  parameter int unsigned DIM_LOW_TMO = 200,
  parameter int unsigned EN_LOW_TMO = 50
) (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Pins and flags
  input wire logic en_pin,
  input wire logic dim_pin,
  input wire logic uvlo_flag,
  input wire logic drain_overvoltage_limit_hit,
  input wire logic sink_overvoltage_limit_hit,
  input wire logic ocp_flag,
  input wire logic otp_flag,
  // Outputs and read strobe
  input wire logic power_switch_on,
  input wire logic sink_enable,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  // ==========================================================
  // Low-time counters, saturating so a parked pin never wraps
  logic [19:0] en_lo_ff, dim_lo_ff, nxt_en_lo, nxt_dim_lo;
  always_comb begin
    nxt_en_lo = (srst || en_pin) ? 20'h0 : en_lo_ff + {19'h0, ~&en_lo_ff};
    nxt_dim_lo = (srst || dim_pin) ? 20'h0 : dim_lo_ff + {19'h0, ~&dim_lo_ff};
  end
  always_ff @(posedge clock) begin
    en_lo_ff <= nxt_en_lo;
    dim_lo_ff <= nxt_dim_lo;
  end
  // ==========================================================
  // Assertions
  en_timeout_a: assert property (en_lo_ff > 20'(EN_LOW_TMO + 2) |-> !sink_enable)
    else $error("sinks on after long enable low");
  dim_timeout_a: assert property (dim_lo_ff > 20'(DIM_LOW_TMO + 2) |-> !sink_enable)
    else $error("sinks on after long dimming low");
  drain_ovp_off_a: assert property (drain_overvoltage_limit_hit |=>
    !power_switch_on && !sink_enable) else $error("drain overvoltage not acted on");
  sink_ovp_off_a: assert property (sink_overvoltage_limit_hit |=> !power_switch_on)
    else $error("sink overvoltage not acted on");
  ovp_latch_a: assert property (drain_overvoltage_limit_hit && sink_enable |=>
    !sink_enable [*8]) else $error("latch-off released early");
  ocp_blank_a: assert property (ocp_flag |=> !power_switch_on)
    else $error("switch on during overcurrent");
  uvlo_off_a: assert property (uvlo_flag |=> !power_switch_on && !sink_enable)
    else $error("running in undervoltage");
  otp_off_a: assert property (otp_flag |=> !power_switch_on && !sink_enable)
    else $error("running in overtemperature");
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside read slot");
  start_c: cover property ($rose(sink_enable));
  ocp_c: cover property (ocp_flag && sink_enable);
  latch_c: cover property (drain_overvoltage_limit_hit && sink_enable);
endmodule : lbp_ctrl_chk
bind lbp_ctrl lbp_ctrl_chk #(.DIM_LOW_TMO(DIM_LOW_TMO), .EN_LOW_TMO(EN_LOW_TMO)) u_chk (
  .clock(clock), .srst(srst), .en_pin(en_pin), .dim_pin(dim_pin), .uvlo_flag(uvlo_flag),
  .drain_overvoltage_limit_hit(drain_overvoltage_limit_hit),
  .sink_overvoltage_limit_hit(sink_overvoltage_limit_hit), .ocp_flag(ocp_flag),
  .otp_flag(otp_flag), .power_switch_on(power_switch_on), .sink_enable(sink_enable),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata));
`default_nettype wire

// [tb/lbp_host_model.sv]
/*
  Host pin model: enable level plus dimming low, high or pulse train.
  Assumes the bench changes the request just after a clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module lbp_host_model (
  // Clock
  input wire logic clock,
  // Requested pattern
  input wire logic en_req,
  input wire logic [1:0] dim_req,
  input wire logic [7:0] hi_cyc,
  input wire logic [7:0] per_cyc,
  // Host pins
  output var logic en_pin = 1'b0,
  output var logic dim_pin = 1'b0
);
  logic [7:0] ph_ff = 8'h0;
  logic [7:0] nxt_ph;
  always_comb begin
    nxt_ph = (ph_ff + 8'h1 >= per_cyc) ? 8'h0 : ph_ff + 8'h1;
  end
  always @(posedge clock) begin
    ph_ff <= nxt_ph;
    en_pin <= en_req;
    dim_pin <= dim_req[1] ? (ph_ff < hi_cyc) : dim_req[0];
  end
endmodule : lbp_host_model
`default_nettype wire

// [tb/tb_led_boost_pwm_enable_fault_ctrl.sv]
/*
  Self-checking bench for lbp_ctrl with short timeouts.
  Assumes the host model drives the pins; flags come from the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_led_boost_pwm_enable_fault_ctrl;
  logic clock = 1'b0, srst = 1'b1, en_req = 1'b0, en_pin, dim_pin, onewire_ok = 1'b0;
  logic [1:0] dim_req = 2'd0;
  logic [7:0] hi_cyc = 8'd25, per_cyc = 8'd100, reg_addr = 8'h0;
  logic [8:0] onewire_code = 9'h155;
  logic uvlo = 1'b0, drain = 1'b0, sinkov = 1'b0, ocp = 1'b0, otp = 1'b0;
  logic power_switch_on, sink_enable, duty_mode, irq, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [9:0] level;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  int err_total = 0, checks = 0;
  always #12.5 clock = ~clock;
  lbp_host_model u_host (.clock(clock), .en_req(en_req), .dim_req(dim_req),
    .hi_cyc(hi_cyc), .per_cyc(per_cyc), .en_pin(en_pin), .dim_pin(dim_pin));
  lbp_ctrl #(.DIM_LOW_TMO(200), .EN_LOW_TMO(50)) u_dut (.clock(clock), .srst(srst),
    .en_pin(en_pin), .dim_pin(dim_pin), .onewire_ok(onewire_ok),
    .onewire_code(onewire_code), .uvlo_flag(uvlo), .drain_overvoltage_limit_hit(drain),
    .sink_overvoltage_limit_hit(sinkov), .ocp_flag(ocp), .otp_flag(otp),
    .power_switch_on(power_switch_on), .sink_enable(sink_enable),
    .led_current_sink_input_level(level), .duty_mode(duty_mode), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq(irq));
  // ==========================================================
  // Tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock) begin reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1; end
    @(posedge clock) reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock) begin reg_addr <= a; reg_rd <= 1'b1; end
    @(posedge clock) reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rd
  task automatic start(input logic ow, input logic [1:0] dm);
    int n;
    @(posedge clock) begin en_req <= 1'b1; dim_req <= dm; end
    if (ow) begin
      cyc(20);
      @(posedge clock) onewire_ok <= 1'b1;
      @(posedge clock) onewire_ok <= 1'b0;
    end
    n = 0;
    while (sink_enable !== 1'b1 && n < 4300) begin
      cyc(1);
      n++;
    end
    chk(32'(sink_enable), 32'h1);
  endtask : start
  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  // ==========================================================
  // Tests
  initial begin
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    rd(lbp_pkg::OFS_CTRL, 32'h1);
    rd(8'h40, 32'h0);
    @(posedge clock) en_req <= 1'b1;
    cyc(4200);
    chk(32'(sink_enable), 32'h0);
    $display("Test pins done");
    start(1'b1, 2'd1);
    chk(32'(duty_mode), 32'h0);
    chk(32'(level), 32'h2ab);
    @(posedge clock) en_req <= 1'b0;
    cyc(60);
    chk(32'(sink_enable), 32'h0);
    start(1'b0, 2'd2);
    chk(32'(duty_mode), 32'h1);
    cyc(600);
    chk(32'(level), 32'h100);
    $display("Test dimming done");
    wr(lbp_pkg::OFS_IRQ_STAT, 32'h7f);
    @(posedge clock) ocp <= 1'b1;
    @(posedge clock) ocp <= 1'b0;
    #1 chk(32'(power_switch_on), 32'h0);
    cyc(40);
    chk(32'(power_switch_on), 32'h1);
    chk(32'(irq), 32'h0);
    for (int i = 0; i < 2; i++) begin
      wr(lbp_pkg::OFS_IRQ_MASK, 32'h8 << i);
      @(posedge clock) if (i == 0) uvlo <= 1'b1; else otp <= 1'b1;
      cyc(5);
      chk(32'(sink_enable), 32'h0);
      chk(32'(irq), 32'h1);
      @(posedge clock) begin uvlo <= 1'b0; otp <= 1'b0; end
      cyc(4);
      chk(32'(sink_enable), 32'h1);
      wr(lbp_pkg::OFS_IRQ_STAT, 32'h8 << i);
      cyc(3);
      chk(32'(irq), 32'h0);
    end
    $display("Test faults done");
    @(posedge clock) dim_req <= 2'd1;
    @(posedge clock) drain <= 1'b1;
    @(posedge clock) drain <= 1'b0;
    cyc(100);
    chk(32'(sink_enable), 32'h0);
    rd(lbp_pkg::OFS_STAT, 32'h7);
    @(posedge clock) dim_req <= 2'd0;
    cyc(3);
    start(1'b0, 2'd1);
    chk(32'(level), 32'h3ff);
    @(posedge clock) sinkov <= 1'b1;
    @(posedge clock) sinkov <= 1'b0;
    cyc(20);
    chk(32'(sink_enable), 32'h0);
    @(posedge clock) dim_req <= 2'd0;
    cyc(3);
    start(1'b0, 2'd1);
    $display("Test overvoltage done");
    wr(lbp_pkg::OFS_CTRL, 32'h0);
    cyc(3);
    chk(32'(sink_enable), 32'h0);
    rd(lbp_pkg::OFS_CTRL, 32'h0);
    wr(lbp_pkg::OFS_CTRL, 32'h1);
    start(1'b0, 2'd1);
    $display("Test allow done");
    @(posedge clock) dim_req <= 2'd0;
    cyc(215);
    chk(32'(sink_enable), 32'h0);
    $display("Test timeout done");
    report_and_stop();
  end
  // Watchdog, well past the expected run length
  initial begin
    #1000000;
    err_total++;
    report_and_stop();
  end
endmodule : tb_led_boost_pwm_enable_fault_ctrl
`default_nettype wire
